/* rlcs_defs.svh */
`ifndef RLCS_DEFS_SVH
`define RLCS_DEFS_SVH

// Register offsets on the byte-wide register port.
`define RLCS_OFF_EDGE      8'h0b
`define RLCS_OFF_CONT      8'h0d
`define RLCS_OFF_SWPRE     8'h0e
`define RLCS_OFF_TMO_LO    8'h10
`define RLCS_OFF_TMO_HI    8'h11
`define RLCS_OFF_IRQ_STAT  8'h20
`define RLCS_OFF_IRQ_MASK  8'h21

// Field positions.
`define RLCS_SWING_LSB     4
`define RLCS_PRE_LSB       0
`define RLCS_CONT_B_N      5
`define RLCS_CONT_B_P      4
`define RLCS_CONT_A_N      1
`define RLCS_CONT_A_P      0
`define RLCS_IRQ_CONT_A    0
`define RLCS_IRQ_CONT_B    1
`define RLCS_IRQ_ABORT     2

// Reset values.
`define RLCS_RST_EDGE      8'h00
`define RLCS_RST_CODE      2'h0
`define RLCS_RST_TMO       8'hff
`define RLCS_RST_IRQ       3'h0

// Strap codes that the mapping produces.
`define RLCS_CODE_00       2'h0
`define RLCS_CODE_01       2'h1
`define RLCS_CODE_10       2'h2

// Final value of the boot counter; the straps are loaded one count before it, at edge 3 after
// release, the first edge at which the second synchroniser stage holds the pin level.
`define RLCS_STRAP_SETTLE  2'h3

`endif

/* rlcs_pkg.sv */
`default_nettype none
package rlcs_pkg;
	// Level seen on a three-level strap pin by its pad comparator.
	typedef enum logic [1:0] {
		RLCS_STRAP_LOW  = 2'b00,
		RLCS_STRAP_MID  = 2'b01,
		RLCS_STRAP_HIGH = 2'b10
	} rlcs_strap_t;

	// State of the turnaround timer.
	typedef enum logic {
		RLCS_TA_IDLE = 1'b0,
		RLCS_TA_RUN  = 1'b1
	} rlcs_ta_state_t;

	// One request on the register port.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       we;
		logic       re;
	} rlcs_bus_t;

	// High-speed transmitter settings handed to the analog lanes.
	typedef struct packed {
		logic [7:0] edge_rate;
		logic [1:0] swing;
		logic [1:0] preemph;
	} rlcs_hs_cfg_t;
endpackage : rlcs_pkg
`default_nettype wire

/* rlcs_sync.sv */
`default_nettype none
module rlcs_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_r;

	// Two stages; the first one is read only by the second.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_r <= '0;
			q_o    <= '0;
		end else begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end
endmodule : rlcs_sync
`default_nettype wire

/* rlcs_ta_timer.sv */
`default_nettype none
module rlcs_ta_timer #(
	parameter int CW = 16
) (
	input  wire logic          clk_i,
	input  wire logic          rst_n_i,
	input  wire logic          tick_i,
	input  wire logic          req_i,
	input  wire logic          ack_i,
	input  wire logic [CW-1:0] reload_i,
	output logic               active_o,
	output logic               abort_o
);
	import rlcs_pkg::*;

	rlcs_ta_state_t st_r;
	logic [CW-1:0]  cnt_r;
	logic           expire;

	// Expiry only counts on a low-power transmit clock edge, never on the fast clock.
	assign expire = (st_r == RLCS_TA_RUN) && !req_i && !ack_i && tick_i && (cnt_r == '0);

	// A fresh request always reloads, even while a previous one still runs.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r  <= RLCS_TA_IDLE;
			cnt_r <= '0;
		end else if (req_i) begin
			st_r  <= RLCS_TA_RUN; // [RQ10]
			cnt_r <= reload_i; // [RQ10]
		end else if (st_r == RLCS_TA_RUN) begin
			// Expiry coincides with a tick, so the order of these tests is the priority.
			if (ack_i) begin
				st_r <= RLCS_TA_IDLE; // [RQ10]
			end else if (expire) begin
				st_r <= RLCS_TA_IDLE; // [RQ11]
			end else if (tick_i) begin
				cnt_r <= cnt_r - 1'b1; // [RQ12]
			end
		end
	end

	// Outputs are registered so the top sees clean levels and pulses.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			active_o <= 1'b0;
			abort_o  <= 1'b0;
		end else begin
			active_o <= req_i || ((st_r == RLCS_TA_RUN) && !ack_i && !expire);
			abort_o  <= expire; // [RQ11]
		end
	end

	sequence s_run_ack;
		(st_r == RLCS_TA_RUN) && ack_i && !req_i;
	endsequence

	property p_ack_stops;
		@(posedge clk_i) disable iff (!rst_n_i) s_run_ack |=> (st_r == RLCS_TA_IDLE) ##1 !active_o;
	endproperty
	a_ack_stops: assert property (p_ack_stops) else $error("timer kept running after ack"); // [RQ10]

	property p_req_reload;
		@(posedge clk_i) disable iff (!rst_n_i) req_i |=> (cnt_r == $past(reload_i)) && active_o;
	endproperty
	a_req_reload: assert property (p_req_reload) else $error("timer not reloaded"); // [RQ10]

	property p_abort_cause;
		@(posedge clk_i) disable iff (!rst_n_i)
			abort_o |-> $past(cnt_r == '0) && $past(tick_i) && $past(st_r == RLCS_TA_RUN)
			&& (st_r == RLCS_TA_IDLE);
	endproperty
	a_abort_cause: assert property (p_abort_cause) else $error("abort without expiry"); // [RQ11]

	property p_no_tick_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
			(st_r == RLCS_TA_RUN) && !tick_i && !req_i |=> $stable(cnt_r);
	endproperty
	a_no_tick_hold: assert property (p_no_tick_hold) else $error("count moved without tick"); // [RQ12]
endmodule : rlcs_ta_timer
`default_nettype wire

/* rlcs_regs.sv */
// Overview of operation
// RQ1: Four 2-bit high-speed edge-rate fields, lanes 3 down to 0, load from the edge-rate strap after reset and are software writable.
// RQ2: Edge-rate code 00 is 200 ps, 01 is 150 ps, 10 is 250 ps, 11 is 300 ps, and strap low, mid, high give 00, 01, 10.
// RQ3: Read-only side-B lane-0 negative and positive contention flags sit at bits 5 and 4, one when contention is seen.
// RQ4: Read-only side-A lane-0 negative and positive contention flags sit at bits 1 and 0 and reset to zero.
// RQ5: The swing field in bits 5:4 loads from both configuration straps after reset and stays writable.
// RQ6: Swing code 00 is 180 mV, 01 is 200 mV, 1X is 220 mV, and strap0 mid, or strap0 low with strap1 not high, gives 01.
// RQ7: The pre-emphasis field in bits 1:0 loads from strap1, mid or low giving 01 and high giving 1X, and stays writable.
// RQ8: Pre-emphasis code 00 is 1.5 dB, 01 is 0 dB and 1X is 2.5 dB.
// RQ9: The low byte of the 16-bit turnaround timeout is read-write and resets to all ones.
// RQ10: The turnaround timer reloads on a turnaround request and stops when the turnaround is acknowledged.
// RQ11: When the timer expires before the acknowledge the turnaround is abandoned.
// RQ12: The timer counts on the low-power transmit clock, not the high-speed clock.
// RQ13: The high byte of the turnaround timeout sits in the next register, read-write, resetting to all ones.
// RQ14: Reserved bits read as zero and writes to them do nothing.
`include "rlcs_defs.svh"
`default_nettype none
module rlcs_regs #(
	parameter int TMO_W = 16
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_n_i,
	input  wire rlcs_pkg::rlcs_bus_t  bus_i,
	output logic [7:0]                rdata_o,
	input  wire rlcs_pkg::rlcs_strap_t edge_rate_strap_i,
	input  wire rlcs_pkg::rlcs_strap_t config_strap0_i,
	input  wire rlcs_pkg::rlcs_strap_t config_strap1_i,
	input  wire logic                 sideb_lane0_neg_contention_i,
	input  wire logic                 sideb_lane0_pos_contention_i,
	input  wire logic                 sidea_lane0_neg_contention_i,
	input  wire logic                 sidea_lane0_pos_contention_i,
	input  wire logic                 low_power_transmit_clk_i,
	input  wire logic                 turnaround_req_i,
	input  wire logic                 turnaround_ack_i,
	output rlcs_pkg::rlcs_hs_cfg_t    hs_cfg_o,
	output logic                      turnaround_active_o,
	output logic                      turnaround_abort_o,
	output logic                      irq_o
);
	import rlcs_pkg::*;

	// Maps one edge-rate strap level to its field code.
	function automatic logic [1:0] edge_code(input rlcs_strap_t s);
		unique case (s)
			RLCS_STRAP_MID:  edge_code = `RLCS_CODE_01; // [RQ2]
			RLCS_STRAP_HIGH: edge_code = `RLCS_CODE_10; // [RQ2]
			default:         edge_code = `RLCS_CODE_00; // [RQ2]
		endcase
	endfunction : edge_code

	// Swing code from both configuration straps.
	function automatic logic [1:0] swing_code(input rlcs_strap_t s0, input rlcs_strap_t s1);
		if (s0 == RLCS_STRAP_HIGH) begin
			swing_code = `RLCS_CODE_10; // [RQ6]
		end else if (s0 == RLCS_STRAP_LOW && s1 == RLCS_STRAP_HIGH) begin
			swing_code = `RLCS_CODE_10; // [RQ6]
		end else begin
			swing_code = `RLCS_CODE_01; // [RQ6]
		end
	endfunction : swing_code

	// Write and read hit for one register offset.
	function automatic logic hit(input logic strobe, input logic [7:0] a, input logic [7:0] off);
		hit = strobe && (a == off);
	endfunction : hit

	logic [1:0]    boot_cnt_r;
	logic          strap_load;
	logic [7:0]    edge_r;
	logic [1:0]    swing_r;
	logic [1:0]    pre_r;
	logic [7:0]    tmo_lo_r;
	logic [7:0]    tmo_hi_r;
	logic [2:0]    irq_stat_r;
	logic [2:0]    irq_mask_r;
	logic [2:0]    irq_set;
	logic [3:0]    cont_s;
	logic [3:0]    cont_d_r;
	logic [5:0]    straps_s;
	logic [2:0]    ctl_s;
	logic          lpt_d_r;
	logic          req_d_r;
	logic          ack_d_r;
	logic          lpt_tick;
	logic          req_edge;
	logic          ack_edge;
	logic          ta_abort;
	logic          ta_active;
	logic [7:0]    cont_view;
	logic [7:0]    rd_nxt;
	rlcs_strap_t   es;
	rlcs_strap_t   s0;
	rlcs_strap_t   s1;

	// Strap pins are static but asynchronous, so they get the same two stages as the rest.
	rlcs_sync #(.W(6)) u_strap_sync (
		.clk_i  (clk_i),
		.rst_n_i(rst_n_i),
		.d_i    ({edge_rate_strap_i, config_strap0_i, config_strap1_i}),
		.q_o    (straps_s)
	);

	// Contention detectors run in the analog front end on their own timing.
	rlcs_sync #(.W(4)) u_cont_sync (
		.clk_i  (clk_i),
		.rst_n_i(rst_n_i),
		.d_i    ({sideb_lane0_neg_contention_i, sideb_lane0_pos_contention_i,
		          sidea_lane0_neg_contention_i, sidea_lane0_pos_contention_i}),
		.q_o    (cont_s)
	);

	// The low-power transmit clock is far slower than clk_i, so it is sampled, not used as a clock.
	rlcs_sync #(.W(3)) u_ctl_sync (
		.clk_i  (clk_i),
		.rst_n_i(rst_n_i),
		.d_i    ({low_power_transmit_clk_i, turnaround_req_i, turnaround_ack_i}),
		.q_o    (ctl_s)
	);

	assign es = rlcs_strap_t'(straps_s[5:4]);
	assign s0 = rlcs_strap_t'(straps_s[3:2]);
	assign s1 = rlcs_strap_t'(straps_s[1:0]);

	// Edge detection on the synchronised copies only.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lpt_d_r  <= 1'b0;
			req_d_r  <= 1'b0;
			ack_d_r  <= 1'b0;
			cont_d_r <= 4'h0;
		end else begin
			lpt_d_r  <= ctl_s[2];
			req_d_r  <= ctl_s[1];
			ack_d_r  <= ctl_s[0];
			cont_d_r <= cont_s;
		end
	end

	assign lpt_tick = ctl_s[2] && !lpt_d_r; // [RQ12]
	assign req_edge = ctl_s[1] && !req_d_r;
	assign ack_edge = ctl_s[0] && !ack_d_r;

	// Straps are caught once the synchronisers hold the pin levels, never under reset.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			boot_cnt_r <= 2'h0;
		end else if (boot_cnt_r != `RLCS_STRAP_SETTLE) begin
			boot_cnt_r <= boot_cnt_r + 2'h1;
		end
	end

	assign strap_load = (boot_cnt_r == `RLCS_STRAP_SETTLE - 2'h1);

	// Edge-rate fields: strap load first, software after.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			edge_r <= `RLCS_RST_EDGE;
		end else if (strap_load) begin
			edge_r <= {4{edge_code(es)}}; // [RQ1]
		end else if (hit(bus_i.we, bus_i.addr, `RLCS_OFF_EDGE)) begin
			edge_r <= bus_i.wdata; // [RQ1]
		end
	end

	// Swing and pre-emphasis share one register; bits 7:6 and 3:2 are not stored.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			swing_r <= `RLCS_RST_CODE;
			pre_r   <= `RLCS_RST_CODE;
		end else if (strap_load) begin
			swing_r <= swing_code(s0, s1); // [RQ5]
			pre_r   <= (s1 == RLCS_STRAP_HIGH) ? `RLCS_CODE_10 : `RLCS_CODE_01; // [RQ7] [RQ8]
		end else if (hit(bus_i.we, bus_i.addr, `RLCS_OFF_SWPRE)) begin
			swing_r <= bus_i.wdata[`RLCS_SWING_LSB +: 2]; // [RQ5] [RQ14]
			pre_r   <= bus_i.wdata[`RLCS_PRE_LSB +: 2]; // [RQ7] [RQ8] [RQ14]
		end
	end

	// Turnaround timeout bytes; a change takes effect at the next request.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tmo_lo_r <= `RLCS_RST_TMO; // [RQ9]
			tmo_hi_r <= `RLCS_RST_TMO; // [RQ13]
		end else begin
			if (hit(bus_i.we, bus_i.addr, `RLCS_OFF_TMO_LO)) begin
				tmo_lo_r <= bus_i.wdata; // [RQ9]
			end
			if (hit(bus_i.we, bus_i.addr, `RLCS_OFF_TMO_HI)) begin
				tmo_hi_r <= bus_i.wdata; // [RQ13]
			end
		end
	end

	rlcs_ta_timer #(.CW(TMO_W)) u_ta_timer (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.tick_i  (lpt_tick),
		.req_i   (req_edge),
		.ack_i   (ack_edge),
		.reload_i(TMO_W'({tmo_hi_r, tmo_lo_r})),
		.active_o(ta_active),
		.abort_o (ta_abort)
	);

	// New contention on either side, or an abandoned turnaround, raises a sticky bit.
	assign irq_set[`RLCS_IRQ_CONT_A] = |(cont_s[1:0] & ~cont_d_r[1:0]);
	assign irq_set[`RLCS_IRQ_CONT_B] = |(cont_s[3:2] & ~cont_d_r[3:2]);
	assign irq_set[`RLCS_IRQ_ABORT]  = ta_abort;

	// Write-one-to-clear, with a same-cycle event winning over the clear.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_stat_r <= `RLCS_RST_IRQ;
		end else if (hit(bus_i.we, bus_i.addr, `RLCS_OFF_IRQ_STAT)) begin
			irq_stat_r <= (irq_stat_r & ~bus_i.wdata[2:0]) | irq_set;
		end else begin
			irq_stat_r <= irq_stat_r | irq_set;
		end
	end

	// Mask register; a one lets the matching status bit reach the line.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_mask_r <= `RLCS_RST_IRQ;
		end else if (hit(bus_i.we, bus_i.addr, `RLCS_OFF_IRQ_MASK)) begin
			irq_mask_r <= bus_i.wdata[2:0];
		end
	end

	// Contention flags are live levels; the status register offers nothing to write.
	always_comb begin
		cont_view = 8'h00; // [RQ14]
		cont_view[`RLCS_CONT_B_N] = cont_s[3]; // [RQ3]
		cont_view[`RLCS_CONT_B_P] = cont_s[2]; // [RQ3]
		cont_view[`RLCS_CONT_A_N] = cont_s[1]; // [RQ4]
		cont_view[`RLCS_CONT_A_P] = cont_s[0]; // [RQ4]
	end

	// Read mux; an unmapped offset, or no read at all, returns zero.
	always_comb begin
		rd_nxt = 8'h00;
		if (bus_i.re) begin
			unique case (bus_i.addr)
				`RLCS_OFF_EDGE:     rd_nxt = edge_r;
				`RLCS_OFF_CONT:     rd_nxt = cont_view;
				`RLCS_OFF_SWPRE:    rd_nxt = {2'h0, swing_r, 2'h0, pre_r}; // [RQ14]
				`RLCS_OFF_TMO_LO:   rd_nxt = tmo_lo_r;
				`RLCS_OFF_TMO_HI:   rd_nxt = tmo_hi_r;
				`RLCS_OFF_IRQ_STAT: rd_nxt = {5'h00, irq_stat_r};
				`RLCS_OFF_IRQ_MASK: rd_nxt = {5'h00, irq_mask_r};
				default:            rd_nxt = 8'h00;
			endcase
		end
	end

	// All top outputs come from flops.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o             <= 8'h00;
			irq_o               <= 1'b0;
			hs_cfg_o            <= '0;
			turnaround_active_o <= 1'b0;
			turnaround_abort_o  <= 1'b0;
		end else begin
			rdata_o             <= rd_nxt;
			irq_o               <= |(irq_stat_r & irq_mask_r);
			hs_cfg_o            <= '{edge_rate: edge_r, swing: swing_r, preemph: pre_r};
			turnaround_active_o <= ta_active;
			turnaround_abort_o  <= ta_abort; // [RQ11]
		end
	end

	sequence s_strap_load;
		strap_load ##1 1'b1;
	endsequence

	property p_strap_edge;
		@(posedge clk_i) disable iff (!rst_n_i)
			s_strap_load |-> edge_r == {4{edge_code($past(es))}};
	endproperty
	a_strap_edge: assert property (p_strap_edge) else $error("edge rate not taken from strap"); // [RQ1]

	property p_strap_swpre;
		@(posedge clk_i) disable iff (!rst_n_i)
			s_strap_load |-> swing_r == swing_code($past(s0), $past(s1))
			&& pre_r == (($past(s1) == RLCS_STRAP_HIGH) ? 2'h2 : 2'h1);
	endproperty
	a_strap_swpre: assert property (p_strap_swpre) else $error("swing or pre not from straps"); // [RQ5]

	property p_tmo_write;
		@(posedge clk_i) disable iff (!rst_n_i)
			bus_i.we && bus_i.addr == `RLCS_OFF_TMO_LO
			|=> tmo_lo_r == $past(bus_i.wdata) ##1 rdata_o == ($past(bus_i.re)
			&& $past(bus_i.addr) == `RLCS_OFF_TMO_LO ? tmo_lo_r : rdata_o);
	endproperty
	a_tmo_write: assert property (p_tmo_write) else $error("timeout low byte not stored"); // [RQ9]

	property p_swpre_reserved;
		@(posedge clk_i) disable iff (!rst_n_i)
			bus_i.re && bus_i.addr == `RLCS_OFF_SWPRE |=> (rdata_o & 8'hcc) == 8'h00;
	endproperty
	a_swpre_reserved: assert property (p_swpre_reserved) else $error("reserved bits not zero"); // [RQ14]

	property p_cont_read;
		@(posedge clk_i) disable iff (!rst_n_i)
			bus_i.re && bus_i.addr == `RLCS_OFF_CONT
			|=> rdata_o == {2'h0, $past(cont_s[3:2]), 2'h0, $past(cont_s[1:0])};
	endproperty
	a_cont_read: assert property (p_cont_read) else $error("contention flags misread"); // [RQ3]

	property p_irq_line;
		@(posedge clk_i) disable iff (!rst_n_i) ##1 irq_o == |($past(irq_stat_r & irq_mask_r));
	endproperty
	a_irq_line: assert property (p_irq_line) else $error("interrupt line wrong");

	property p_abort_sticky;
		@(posedge clk_i) disable iff (!rst_n_i)
			ta_abort |=> irq_stat_r[`RLCS_IRQ_ABORT] ##1 turnaround_abort_o == 1'b0 || ta_abort;
	endproperty
	a_abort_sticky: assert property (p_abort_sticky) else $error("abort not recorded"); // [RQ11]
endmodule : rlcs_regs
`default_nettype wire

/* rlcs_regs_test.sv */
`default_nettype none
// Compares one seen value against its expected value and counts the check.
`define CHK(nm, e, g) begin \
	n_checks++; \
	if ((g) !== (e)) begin \
		bad_count++; \
		$display("MISMATCH %s expected %h seen %h", nm, e, g); \
	end \
end
module rlcs_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	import rlcs_pkg::*;

	logic         clk_i    = 1'b0;
	logic         rst_n_i  = 1'b0;
	rlcs_bus_t    bus_r    = '0;
	rlcs_strap_t  erc_r    = RLCS_STRAP_LOW;
	rlcs_strap_t  s0_r     = RLCS_STRAP_LOW;
	rlcs_strap_t  s1_r     = RLCS_STRAP_LOW;
	logic [3:0]   cont_r   = 4'h0;
	logic         lp_r     = 1'b0;
	logic         req_r    = 1'b0;
	logic         ack_r    = 1'b0;
	logic [7:0]   rdata_o;
	rlcs_hs_cfg_t hs_cfg_o;
	logic         active_o;
	logic         abort_o;
	logic         irq_o;
	int           bad_count = 0;
	int           n_checks  = 0;
	int           abort_seen = 0;
	logic [7:0]   exp_q[$];
	logic [7:0]   exp_v;
	logic         re_seen = 1'b0;
	logic [31:0]  seed = 32'hafe9;
	logic [1:0]   ec;
	logic [1:0]   sw;
	logic [1:0]   pr;
	rlcs_strap_t  tab_e[4] = '{RLCS_STRAP_LOW, RLCS_STRAP_MID, RLCS_STRAP_HIGH, RLCS_STRAP_LOW};
	rlcs_strap_t  tab_0[4] = '{RLCS_STRAP_MID, RLCS_STRAP_LOW, RLCS_STRAP_HIGH, RLCS_STRAP_LOW};
	rlcs_strap_t  tab_1[4] = '{RLCS_STRAP_LOW, RLCS_STRAP_MID, RLCS_STRAP_LOW, RLCS_STRAP_HIGH};

	rlcs_regs rlcs_regs_i (
		.clk_i                        (clk_i),
		.rst_n_i                      (rst_n_i),
		.bus_i                        (bus_r),
		.rdata_o                      (rdata_o),
		.edge_rate_strap_i            (erc_r),
		.config_strap0_i              (s0_r),
		.config_strap1_i              (s1_r),
		.sideb_lane0_neg_contention_i (cont_r[3]),
		.sideb_lane0_pos_contention_i (cont_r[2]),
		.sidea_lane0_neg_contention_i (cont_r[1]),
		.sidea_lane0_pos_contention_i (cont_r[0]),
		.low_power_transmit_clk_i     (lp_r),
		.turnaround_req_i             (req_r),
		.turnaround_ack_i             (ack_r),
		.hs_cfg_o                     (hs_cfg_o),
		.turnaround_active_o          (active_o),
		.turnaround_abort_o           (abort_o),
		.irq_o                        (irq_o)
	);

	// Free-running 200 MHz clock.
	always #2.5 clk_i = ~clk_i;

	// Read data stands only in the cycle after the strobe, so it is taken at the next edge.
	always @(posedge clk_i) begin
		if (re_seen === 1'b1) begin
			if (exp_q.size() == 0) `CHK("read queue", 1'b1, 1'b0)
			else begin
				exp_v = exp_q.pop_front();
				`CHK("read data", exp_v, rdata_o)
			end
		end
		// Outside the cycle after a read strobe the read data must be zero.
		if (re_seen !== 1'b1 && rst_n_i === 1'b1 && rdata_o !== 8'h00) begin
			`CHK("idle read data", 8'h00, rdata_o)
		end
		re_seen = bus_r.re;
		if (abort_o === 1'b1) abort_seen++;
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction : xs

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		bus_r <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
		@(posedge clk_i);
		bus_r <= '0;
	endtask : wr

	// The expected value is noted before the strobe goes out.
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_i);
		exp_q.push_back(e);
		bus_r <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
		@(posedge clk_i);
		bus_r <= '0;
	endtask : rd

	// Straps are set with reset asserted so they are stable well before release.
	task automatic do_reset(input rlcs_strap_t e, input rlcs_strap_t c0, input rlcs_strap_t c1);
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		erc_r <= e;
		s0_r <= c0;
		s1_r <= c1;
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
	endtask : do_reset

	// One slow low-power clock period of nine system cycles.
	task automatic tick;
		@(posedge clk_i);
		lp_r <= 1'b1;
		repeat (4) @(posedge clk_i);
		lp_r <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask : tick

	task automatic print_verdict;
		if (bad_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : print_verdict

	// Watchdog sized well above the few hundred cycles that the sequence needs.
	initial begin
		#200000;
		bad_count++;
		print_verdict();
	end

	initial begin
		// Strap combinations, each under a fresh reset.
		for (int i = 0; i < 4; i++) begin
			do_reset(tab_e[i], tab_0[i], tab_1[i]);
			ec = (tab_e[i] == RLCS_STRAP_MID) ? 2'h1 : (tab_e[i] == RLCS_STRAP_HIGH) ? 2'h2 : 2'h0;
			sw = (tab_0[i] == RLCS_STRAP_MID ||
				(tab_0[i] == RLCS_STRAP_LOW && tab_1[i] != RLCS_STRAP_HIGH)) ? 2'h1 : 2'h2;
			pr = (tab_1[i] == RLCS_STRAP_HIGH) ? 2'h2 : 2'h1;
			rd(8'h0b, {4{ec}});
			rd(8'h0e, {2'h0, sw, 2'h0, pr});
			rd(8'h10, 8'hff);
			rd(8'h11, 8'hff);
			rd(8'h0d, 8'h00);
			`CHK("edge rate out", {4{ec}}, hs_cfg_o.edge_rate)
		end
		// Every code of each field, with reserved bits written high.
		for (int c = 0; c < 4; c++) begin
			wr(8'h0b, {4{2'(c)}});
			wr(8'h0e, {2'h3, 2'(c), 2'h3, 2'(c)});
			rd(8'h0b, {4{2'(c)}});
			rd(8'h0e, {2'h0, 2'(c), 2'h0, 2'(c)});
			`CHK("hs cfg out", {{4{2'(c)}}, 2'(c), 2'(c)}, hs_cfg_o)
		end
		// Random values through the two timeout bytes and the edge-rate byte.
		repeat (4) begin
			seed = xs(seed);
			wr(8'h10, seed[7:0]);
			wr(8'h11, seed[15:8]);
			wr(8'h0b, seed[23:16]);
			rd(8'h10, seed[7:0]);
			rd(8'h11, seed[15:8]);
			rd(8'h0b, seed[23:16]);
		end
		// Read-only status and an unmapped place refuse writes.
		wr(8'h0d, 8'hff);
		wr(8'h33, 8'hff);
		rd(8'h0d, 8'h00);
		rd(8'h33, 8'h00);
		// Side-A contention, then the interrupt masked, unmasked and cleared.
		cont_r <= 4'h2;
		repeat (4) @(posedge clk_i);
		rd(8'h0d, 8'h02);
		rd(8'h20, 8'h01);
		`CHK("irq masked", 1'b0, irq_o)
		wr(8'h21, 8'h01);
		repeat (3) @(posedge clk_i);
		`CHK("irq raised", 1'b1, irq_o)
		wr(8'h20, 8'h01);
		repeat (3) @(posedge clk_i);
		`CHK("irq cleared", 1'b0, irq_o)
		// Side-B negative wire raises its own status bit, masked off at first.
		cont_r <= 4'ha;
		repeat (4) @(posedge clk_i);
		rd(8'h0d, 8'h22);
		rd(8'h20, 8'h02);
		`CHK("irq side b masked", 1'b0, irq_o)
		wr(8'h21, 8'h07);
		repeat (3) @(posedge clk_i);
		`CHK("irq side b", 1'b1, irq_o)
		wr(8'h20, 8'h02);
		cont_r <= 4'h0;
		// Positive wires of both sides land on their own bits and raise both status bits.
		repeat (4) @(posedge clk_i);
		cont_r <= 4'h5;
		repeat (4) @(posedge clk_i);
		rd(8'h0d, 8'h11);
		rd(8'h20, 8'h03);
		wr(8'h20, 8'h03);
		cont_r <= 4'h0;
		// Turnaround with a count of two and no acknowledge expires on the third tick.
		wr(8'h10, 8'h02);
		wr(8'h11, 8'h00);
		req_r <= 1'b1;
		repeat (8) @(posedge clk_i);
		`CHK("turnaround running", 1'b1, active_o)
		repeat (40) @(posedge clk_i);
		`CHK("no tick no expiry", 0, abort_seen)
		tick();
		tick();
		`CHK("still running", 1'b1, active_o)
		`CHK("no early abort", 0, abort_seen)
		tick();
		repeat (6) @(posedge clk_i);
		`CHK("abort pulse", 1, abort_seen)
		`CHK("abandoned", 1'b0, active_o)
		rd(8'h20, 8'h04);
		`CHK("irq on abort", 1'b1, irq_o)
		req_r <= 1'b0;
		wr(8'h20, 8'h04);
		// A second request is acknowledged in time, so nothing is abandoned.
		req_r <= 1'b1;
		repeat (8) @(posedge clk_i);
		tick();
		tick();
		ack_r <= 1'b1;
		repeat (8) @(posedge clk_i);
		`CHK("stopped by ack", 1'b0, active_o)
		tick();
		tick();
		tick();
		`CHK("no abort after ack", 1, abort_seen)
		repeat (4) @(posedge clk_i);
		`CHK("reads answered", 0, exp_q.size())
		print_verdict();
	end
endmodule : rlcs_regs_test
`undef CHK
`default_nettype wire
